/* fdcrs_pkg.sv */
// Purpose: Constants and types for the rate control and result status block
// Assumes: One clock domain, 8-bit host data
// Notes:   Operation list below
// Operation
// [R1] Register mode chosen by two config bits; third mode when both low.
// [R2] Third mode: input reg bits 1:0 show rate; hold on soft reset.
// [R3] Third mode: input reg bit 3 shows output reg DMA gate enable.
// [R4] Third mode: input reg bits 6:4 read zero.
// [R5] Input reg bit 7 is inverse of sampled disk change pin.
// [R6] Write-only rate config shares input reg address; rate resets to 10.
// [R7] Software writes zero to unused upper bits of rate config.
// [R8] Third mode: precomp-disable bit stored only, read back, soft reset proof.
// [R9] Density output high after hard reset, untouched by soft resets.
// [R10] Rate selection decodes to data rate and density level per drive option.
// [R11] Result phase presents status bytes through the data register.
// [R12] Status 0 bits 7:6 hold termination code.
// [R13] Status 0 bit 5 set on seek, relative seek or recalibrate completion.
// [R14] Status 0 bit 4 flags equipment fault on recalibrate or outward seek.
// [R15] Status 0 holds head in bit 2 and drive in bits 1:0.
// [R16] Unused status bits read zero: st0 bit 3, st1 bits 6 and 3.
// [R17] Status 1 bit 7 set on access past last track sector.
// [R18] Status 1 bit 5 set on CRC error in ID or data field.
// [R19] Status 1 bit 4 set on overrun or underrun.
// [R20] Status 1 bit 2 flags no data conditions.
// [R21] Status 1 bit 1 set when write protect active during write commands.
// [R22] Status 1 bit 0 flags missing address mark.
package fdcrs_pkg;
   localparam logic [9:0] ADDR_DATA      = 10'h3F5;
   localparam logic [9:0] ADDR_DIR_CCR   = 10'h3F7;
   localparam logic [1:0] RATE_RESET     = 2'h2;
   localparam logic       PRECOMP_RESET  = 1'b0;
   localparam logic       DENSITY_RESET  = 1'b1;
   localparam int         RATE_LO_BIT    = 0;
   localparam int         PRECOMP_BIT    = 2;
   localparam int         DMA_GATE_BIT   = 3;
   localparam int         DISK_CHANGE_FLAG_BIT     = 7;
   localparam logic [1:0] TERM_NORMAL    = 2'h0;
   localparam logic [1:0] TERM_ABNORMAL  = 2'h1;
   localparam logic [1:0] TERM_INVALID   = 2'h2;
   localparam logic [1:0] TERM_POLLING   = 2'h3;
   localparam logic [6:0] RECAL_STEPS    = 7'h50;

   typedef enum logic [1:0] {
      FDCRS_MODE_THIRD = 2'b00,
      FDCRS_MODE_ENH   = 2'b01,
      FDCRS_MODE_STD   = 2'b10
   } fdcrs_mode_e;

   typedef enum logic [1:0] {
      FDCRS_RATE_500 = 2'b00,
      FDCRS_RATE_300 = 2'b01,
      FDCRS_RATE_250 = 2'b10,
      FDCRS_RATE_1M  = 2'b11
   } fdcrs_rate_e;

   typedef enum logic [1:0] {
      FDCRS_RES_IDLE = 2'b00,
      FDCRS_RES_ST0  = 2'b01,
      FDCRS_RES_ST1  = 2'b10
   } fdcrs_res_e;
endpackage

/* fdcrs_stat_if.sv */
// Purpose: Carries status bytes 0 and 1 from status builder to top
// Assumes: Single clock
// Notes:   None
`timescale 1ns/1ps
interface fdcrs_stat_if;
   logic [7:0] st0;
   logic [7:0] st1;
   modport builder (output st0, output st1);
   modport user    (input st0, input st1);
endinterface

/* fdcrs_sync.sv */
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Asynchronous pin
// Notes:   First flop read only by second
`timescale 1ns/1ps
module fdcrs_sync
   import fdcrs_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic d,
   output logic      q
);
   logic meta_reg;
   logic meta_next;
   logic q_next;

   always_comb begin
      meta_next = d;
      q_next    = meta_reg;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= 1'b0;
         q        <= 1'b0;
      end else begin
         meta_reg <= meta_next;
         q        <= q_next;
      end
   end
endmodule

/* fdcrs_status.sv */
// Purpose: Builds result status bytes 0 and 1 from a command's completion
// Assumes: Events are one-cycle pulses from the command engine
// Notes:   Status 0 latches at completion; status 1 flags clear at next command start
`timescale 1ns/1ps
module fdcrs_status
   import fdcrs_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       soft_rst,
   input  wire logic       cmd_start,
   input  wire logic       cmd_done,
   input  wire logic [1:0] term_code,
   input  wire logic       seek_cmd,
   input  wire logic       recal_fail,
   input  wire logic       rel_seek_under,
   input  wire logic       head,
   input  wire logic [1:0] drive_number,
   input  wire logic       end_of_track,
   input  wire logic       no_tc,
   input  wire logic       crc_fault,
   input  wire logic       overrun,
   input  wire logic       sector_not_found,
   input  wire logic       wp_active,
   input  wire logic       write_cmd,
   input  wire logic       mark_missing,
   fdcrs_stat_if.builder   st
);
   logic [7:0] st0_reg;
   logic [7:0] st0_next;
   logic [7:0] st1_reg;
   logic [7:0] st1_next;

   always_comb begin
      st0_next = st0_reg;
      st1_next = st1_reg;
      if (cmd_start) begin
         st1_next = 8'h00;
      end
      // Sticky error flags; events in the clearing cycle still land
      if (end_of_track || no_tc)          st1_next[7] = 1'b1; // [R17]
      if (crc_fault)                      st1_next[5] = 1'b1; // [R18]
      if (overrun)                        st1_next[4] = 1'b1; // [R19]
      if (sector_not_found)               st1_next[2] = 1'b1; // [R20]
      if (wp_active && write_cmd)         st1_next[1] = 1'b1; // [R21]
      if (mark_missing)                   st1_next[0] = 1'b1; // [R22]
      st1_next[6] = 1'b0; // [R16]
      st1_next[3] = 1'b0; // [R16]
      if (cmd_done) begin
         st0_next[7:6] = term_code;                         // [R12]
         st0_next[5]   = seek_cmd;                          // [R13]
         st0_next[4]   = recal_fail || rel_seek_under;      // [R14]
         st0_next[3]   = 1'b0;                              // [R16]
         st0_next[2]   = head;                              // [R15]
         st0_next[1:0] = drive_number;                      // [R15]
      end
      if (soft_rst) begin
         st0_next = 8'h00;
         st1_next = 8'h00;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st0_reg <= 8'h00;
         st1_reg <= 8'h00;
      end else begin
         st0_reg <= st0_next;
         st1_reg <= st1_next;
      end
   end

   assign st.st0 = st0_reg;
   assign st.st1 = st1_reg;
endmodule

/* fdcrs_top.sv */
// Purpose: Digital input / rate config register and result status readout
// Assumes: Host I/O strobes are synchronous to CLK_SYS, one cycle wide
// Notes:   Third register mode when both mode bits are low
`timescale 1ns/1ps
module fdcrs_top
   import fdcrs_pkg::*;
(
   input  wire logic       CLK_SYS,
   input  wire logic       RST,
   input  wire logic [9:0] ADDR,
   input  wire logic       IO_RD,
   input  wire logic       IO_WR,
   input  wire logic [7:0] WDATA,
   output logic      [7:0] RDATA,
   output logic            RDATA_OE,
   input  wire logic       MODE_IDENT,
   input  wire logic       MODE_MFM,
   input  wire logic [1:0] DRIVE_RATE_OPT,
   input  wire logic       SOFT_RST,
   input  wire logic       DMA_GATE_ENABLE,
   input  wire logic       DISK_CHANGE_IN,
   input  wire logic       WRITE_PROTECT_IN,
   input  wire logic       RESULT_PHASE,
   input  wire logic       CMD_START,
   input  wire logic       CMD_DONE,
   input  wire logic [1:0] TERM_CODE,
   input  wire logic       SEEK_CMD,
   input  wire logic       RECAL_FAIL,
   input  wire logic       REL_SEEK_UNDER,
   input  wire logic       HEAD_ADDR,
   input  wire logic [1:0] DRIVE_NUMBER,
   input  wire logic       END_OF_TRACK,
   input  wire logic       NO_TC,
   input  wire logic       CRC_FAULT,
   input  wire logic       OVERRUN,
   input  wire logic       SECTOR_NOT_FOUND,
   input  wire logic       WRITE_CMD,
   input  wire logic       MARK_MISSING,
   output logic      [1:0] RATE_SELECT,
   output logic      [1:0] DATA_RATE_CODE,
   output logic            DENSITY_SELECT_OUT
);
   fdcrs_stat_if st_if ();

   logic        disk_change_flag_s;
   logic        wp_s;
   fdcrs_mode_e mode;
   logic [1:0]  rate_reg;
   logic [1:0]  rate_next;
   logic        precomp_reg;
   logic        precomp_next;
   logic        density_reg;
   logic        density_next;
   logic [1:0]  drate_reg;
   logic [1:0]  drate_next;
   logic [7:0]  rdata_next;
   logic        oe_next;
   logic        res_idx_reg;
   logic        res_idx_next;
   logic [7:0]  dir_val;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   fdcrs_sync u_sync_disk_change_flag (
      .clk (CLK_SYS),
      .rst (RST),
      .d   (DISK_CHANGE_IN),
      .q   (disk_change_flag_s)
   );

   fdcrs_sync u_sync_wp (
      .clk (CLK_SYS),
      .rst (RST),
      .d   (WRITE_PROTECT_IN),
      .q   (wp_s)
   );

   // ------------------------------------------------------------
   // Status builder
   // ------------------------------------------------------------
   fdcrs_status u_status (
      .clk              (CLK_SYS),
      .rst              (RST),
      .soft_rst         (SOFT_RST),
      .cmd_start        (CMD_START),
      .cmd_done         (CMD_DONE),
      .term_code        (TERM_CODE),
      .seek_cmd         (SEEK_CMD),
      .recal_fail       (RECAL_FAIL),
      .rel_seek_under   (REL_SEEK_UNDER),
      .head             (HEAD_ADDR),
      .drive_number     (DRIVE_NUMBER),
      .end_of_track     (END_OF_TRACK),
      .no_tc            (NO_TC),
      .crc_fault        (CRC_FAULT),
      .overrun          (OVERRUN),
      .sector_not_found (SECTOR_NOT_FOUND),
      .wp_active        (wp_s),
      .write_cmd        (WRITE_CMD),
      .mark_missing     (MARK_MISSING),
      .st               (st_if.builder)
   );

   // ------------------------------------------------------------
   // Mode select and register state
   // ------------------------------------------------------------
   always_comb begin
      if (MODE_IDENT)    mode = FDCRS_MODE_STD;   // [R1]
      else if (MODE_MFM) mode = FDCRS_MODE_ENH;   // [R1]
      else               mode = FDCRS_MODE_THIRD; // [R1]
   end

   always_comb begin
      rate_next    = rate_reg;
      precomp_next = precomp_reg;
      // Soft reset leaves rate, precomp and density untouched
      if (IO_WR && ADDR == ADDR_DIR_CCR) begin
         rate_next = WDATA[RATE_LO_BIT +: 2];                        // [R6] [R2]
         if (mode == FDCRS_MODE_THIRD) precomp_next = WDATA[PRECOMP_BIT]; // [R8]
      end
   end

   // Rate decode by drive option
   always_comb begin
      drate_next   = rate_reg;
      density_next = (rate_reg == FDCRS_RATE_1M) || (rate_reg == FDCRS_RATE_500); // [R10]
      if (DRIVE_RATE_OPT == 2'h0 || DRIVE_RATE_OPT == 2'h3) drate_next = rate_reg; // [R10]
      // 300 code maps to 500 for three-mode drives; other options keep the 300 code
      if (DRIVE_RATE_OPT == 2'h1 && rate_reg == FDCRS_RATE_300) drate_next = FDCRS_RATE_500; // [R10]
      if (MODE_IDENT == 1'b0) density_next = ~density_next; // [R10]
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   always_comb begin
      dir_val = 8'h00;
      dir_val[DISK_CHANGE_FLAG_BIT] = ~disk_change_flag_s; // [R5]
      case (mode)
         FDCRS_MODE_THIRD: begin
            dir_val[RATE_LO_BIT +: 2] = rate_reg;        // [R2]
            dir_val[PRECOMP_BIT]      = precomp_reg;     // [R8]
            dir_val[DMA_GATE_BIT]     = DMA_GATE_ENABLE; // [R3]
            dir_val[6:4]              = 3'h0;            // [R4]
         end
         FDCRS_MODE_ENH: begin
            dir_val[6:3] = 4'hF;
            dir_val[2:1] = rate_reg;
            dir_val[0]   = ~(rate_reg == FDCRS_RATE_1M || rate_reg == FDCRS_RATE_500);
         end
         default: begin
            dir_val[6:0] = 7'h00;
         end
      endcase
   end

   always_comb begin
      rdata_next   = 8'h00;
      oe_next      = 1'b0;
      res_idx_next = res_idx_reg;
      if (CMD_START || SOFT_RST) res_idx_next = 1'b0;
      if (IO_RD && ADDR == ADDR_DIR_CCR) begin
         rdata_next = dir_val;
         oe_next    = 1'b1;
      end else if (IO_RD && ADDR == ADDR_DATA && RESULT_PHASE) begin
         rdata_next   = res_idx_reg ? st_if.st1 : st_if.st0; // [R11]
         oe_next      = 1'b1;
         res_idx_next = ~res_idx_reg;
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         rate_reg           <= RATE_RESET;    // [R2] [R6]
         precomp_reg        <= PRECOMP_RESET;
         density_reg        <= DENSITY_RESET; // [R9]
         drate_reg          <= RATE_RESET;
         RDATA              <= 8'h00;
         RDATA_OE           <= 1'b0;
         res_idx_reg        <= 1'b0;
         RATE_SELECT        <= RATE_RESET;
         DATA_RATE_CODE     <= RATE_RESET;
         DENSITY_SELECT_OUT <= DENSITY_RESET;
      end else begin
         rate_reg           <= rate_next;
         precomp_reg        <= precomp_next;
         density_reg        <= density_next;
         drate_reg          <= drate_next;
         RDATA              <= rdata_next;
         RDATA_OE           <= oe_next;
         res_idx_reg        <= res_idx_next;
         RATE_SELECT        <= rate_reg;
         DATA_RATE_CODE     <= drate_reg;
         DENSITY_SELECT_OUT <= density_reg; // [R9]
      end
   end
endmodule

/* fdcrs_host_bfm.sv */
// Purpose: Host processor model on the I/O strobe bus
// Assumes: Strobes one cycle wide, launched at a rising edge
// Notes:   Data sampled after the answer edge
`timescale 1ns/1ps
module fdcrs_host_bfm (
   input  wire logic       clk,
   output logic      [9:0] addr,
   output logic            io_rd,
   output logic            io_wr,
   output logic      [7:0] wdata,
   input  wire logic [7:0] rdata,
   input  wire logic       rdata_oe
);
   initial begin
      addr = 10'h000;
      io_rd = 1'b0;
      io_wr = 1'b0;
      wdata = 8'h00;
   end
   // Upper bits always written as zero
   task automatic wr(input logic [9:0] a, input logic p, input logic [1:0] r);
      @(posedge clk) begin
         addr <= a;
         io_wr <= 1'b1;
         wdata <= {5'h00, p, r};
      end
      @(posedge clk) io_wr <= 1'b0;
   endtask
   task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic oe);
      @(posedge clk) begin
         addr <= a;
         io_rd <= 1'b1;
      end
      @(posedge clk) io_rd <= 1'b0;
      #1;
      d = rdata;
      oe = rdata_oe;
   endtask
endmodule

/* fdcrs_rs_sva.sv */
// Purpose: Port checks for the rate control and status readout
// Assumes: Single clock domain
// Notes:   Bound to the top module
`timescale 1ns/1ps
module fdcrs_rs_sva (
   input wire logic       CLK_SYS,
   input wire logic       RST,
   input wire logic [9:0] ADDR,
   input wire logic       IO_RD,
   input wire logic       IO_WR,
   input wire logic [7:0] WDATA,
   input wire logic [7:0] RDATA,
   input wire logic       RDATA_OE,
   input wire logic       MODE_IDENT,
   input wire logic       MODE_MFM,
   input wire logic       DMA_GATE_ENABLE,
   input wire logic       DISK_CHANGE_IN,
   input wire logic       RESULT_PHASE,
   input wire logic       SOFT_RST,
   input wire logic [1:0] RATE_SELECT,
   input wire logic       DENSITY_SELECT_OUT
);
   // ----------------------------------------
   // Helper ages
   // ----------------------------------------
   logic       m3, rd3, dc_q;
   logic [2:0] dc_age, wr_age;
   assign m3 = !MODE_IDENT && !MODE_MFM;
   assign rd3 = IO_RD && ADDR == 10'h3F7;
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         dc_q <= 1'b0;
         dc_age <= 3'h0;
         wr_age <= 3'h0;
      end else begin
         dc_q <= DISK_CHANGE_IN;
         dc_age <= (DISK_CHANGE_IN != dc_q) ? 3'h0 : (dc_age == 3'h7) ? dc_age : dc_age + 3'h1;
         wr_age <= (IO_WR || !m3) ? 3'h0 : (wr_age == 3'h7) ? wr_age : wr_age + 3'h1;
      end
   end
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   a_rd_answer: assert property (rd3 |=> RDATA_OE) else $error("no answer to read");
   a_rd_refused: assert property (IO_RD && ADDR != 10'h3F7 && ADDR != 10'h3F5 |=> !RDATA_OE)
      else $error("read of unmapped address answered");
   a_rate_write: assert property (IO_WR && ADDR == 10'h3F7 |-> ##2 RATE_SELECT == $past(WDATA[1:0], 2))
      else $error("rate not taken from write");
   a_dir_rate: assert property (m3 && rd3 |=> RDATA[1:0] == RATE_SELECT) else $error("rate readback wrong");
   a_dir_dma: assert property (m3 && rd3 |=> RDATA[3] == $past(DMA_GATE_ENABLE))
      else $error("dma gate readback wrong");
   a_dir_zero: assert property (m3 && rd3 |=> RDATA[6:4] == 3'h0) else $error("bits 6 to 4 not zero");
   a_dir_change: assert property (m3 && rd3 && dc_age >= 3'h4 |=> RDATA[7] == !$past(DISK_CHANGE_IN))
      else $error("disk change not inverted");
   a_st_unused: assert property (RESULT_PHASE && IO_RD && ADDR == 10'h3F5 |=> RDATA_OE && !RDATA[3])
      else $error("status read wrong");
   a_soft_keep: assert property (SOFT_RST && wr_age >= 3'h4 |=>
      $stable(DENSITY_SELECT_OUT) && $stable(RATE_SELECT)) else $error("soft reset changed rate or density");
   a_reset_vals: assert property ($fell(RST) |-> RATE_SELECT == 2'h2 && DENSITY_SELECT_OUT)
      else $error("wrong values after reset");
endmodule
bind fdcrs_top fdcrs_rs_sva sva_u (.CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .IO_RD(IO_RD), .IO_WR(IO_WR),
   .WDATA(WDATA), .RDATA(RDATA), .RDATA_OE(RDATA_OE), .MODE_IDENT(MODE_IDENT), .MODE_MFM(MODE_MFM),
   .DMA_GATE_ENABLE(DMA_GATE_ENABLE), .DISK_CHANGE_IN(DISK_CHANGE_IN), .RESULT_PHASE(RESULT_PHASE),
   .SOFT_RST(SOFT_RST), .RATE_SELECT(RATE_SELECT), .DENSITY_SELECT_OUT(DENSITY_SELECT_OUT));

/* fdcrs_top_tb.sv */
// Purpose: Self-checking bench for the rate control and status readout
// Assumes: Host model drives the I/O bus
// Notes:   Third register mode unless a test says otherwise
`timescale 1ns/1ps
module fdcrs_top_tb;
   import fdcrs_pkg::*;
   logic       clk, rst, mi, mf, sr, dma, dc, wp, rp, cs, cd, seek, rf, rsu, hd;
   logic       eot, notc, crc, ovr, snf, wcmd, mm, oe, rdoe, rd, wr, dens;
   logic [1:0] opt, tc, dn, rsel, drc;
   logic [7:0] d, wd, rdat;
   logic [9:0] adr;
   int         n_mismatch = 0;
   int         checks_done = 0;
   fdcrs_host_bfm host_u (.clk(clk), .addr(adr), .io_rd(rd), .io_wr(wr), .wdata(wd), .rdata(rdat),
      .rdata_oe(rdoe));
   fdcrs_top dut_u (.CLK_SYS(clk), .RST(rst), .ADDR(adr), .IO_RD(rd), .IO_WR(wr), .WDATA(wd), .RDATA(rdat),
      .RDATA_OE(rdoe), .MODE_IDENT(mi), .MODE_MFM(mf), .DRIVE_RATE_OPT(opt), .SOFT_RST(sr),
      .DMA_GATE_ENABLE(dma), .DISK_CHANGE_IN(dc), .WRITE_PROTECT_IN(wp), .RESULT_PHASE(rp), .CMD_START(cs),
      .CMD_DONE(cd), .TERM_CODE(tc), .SEEK_CMD(seek), .RECAL_FAIL(rf), .REL_SEEK_UNDER(rsu), .HEAD_ADDR(hd),
      .DRIVE_NUMBER(dn), .END_OF_TRACK(eot), .NO_TC(notc), .CRC_FAULT(crc), .OVERRUN(ovr),
      .SECTOR_NOT_FOUND(snf), .WRITE_CMD(wcmd), .MARK_MISSING(mm), .RATE_SELECT(rsel),
      .DATA_RATE_CODE(drc), .DENSITY_SELECT_OUT(dens));
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      checks_done++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #100000;
      n_mismatch++;
      report_and_stop();
   end
   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      {mi, mf, sr, dma, wp, rp, cs, cd, seek, rf, rsu, hd, eot, notc, crc, ovr, snf, wcmd, mm} = '0;
      {opt, tc, dn} = '0;
      dc = 1'b1;
      rst = 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      host_u.rd(10'h3F7, d, oe);
      chk(d, 8'h02);
      chk({2'h0, oe, rsel, drc, dens}, 8'h35);
      for (int r = 0; r < 4; r++) begin
         @(posedge clk) {dc, dma} <= r[1:0];
         host_u.wr(10'h3F7, 1'b1, r[1:0]);
         repeat (3) @(posedge clk);
         host_u.rd(10'h3F7, d, oe);
         chk(d, {!r[1], 3'h0, r[0], 1'b1, r[1:0]});
         chk({rsel, drc, 3'h0, dens}, {r[1:0], r[1:0], 3'h0, r == 1 || r == 2});
      end
      @(posedge clk) sr <= 1'b1;
      @(posedge clk) sr <= 1'b0;
      host_u.rd(10'h3F7, d, oe);
      chk(d, 8'h0F);
      chk({5'h00, rsel, dens}, 8'h06);
      @(posedge clk) opt <= 2'h1;
      host_u.wr(10'h3F7, 1'b0, 2'h1);
      repeat (3) @(posedge clk);
      #1;
      chk({6'h00, drc}, 8'h00);
      @(posedge clk) opt <= 2'h2;
      repeat (3) @(posedge clk);
      #1;
      chk({6'h00, drc}, 8'h01);
      @(posedge clk) {opt, mi} <= 3'h1;
      host_u.wr(10'h3F7, 1'b0, 2'h0);
      repeat (3) @(posedge clk);
      host_u.rd(10'h3F7, d, oe);
      chk(d, 8'h00);
      chk({7'h00, dens}, 8'h01);
      @(posedge clk) {mi, mf} <= 2'h1;
      host_u.rd(10'h3F7, d, oe);
      chk(d, 8'h78);
      @(posedge clk) mf <= 1'b0;
      host_u.rd(10'h3F6, d, oe);
      chk({7'h00, oe}, 8'h00);
      host_u.rd(10'h3F5, d, oe);
      chk({7'h00, oe}, 8'h00);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk) {cs, wcmd, wp} <= {2'h3, i[0]};
         @(posedge clk) cs <= 1'b0;
         repeat (2) @(posedge clk);
         {eot, notc, crc, ovr, snf, mm} <= {i == 1, i == 2, i[1], !i[0], i[1], !i[1]};
         @(posedge clk) {eot, notc, crc, ovr, snf, mm} <= '0;
         {cd, tc, seek, rf, rsu, hd, dn} <= {1'b1, i[1:0], i[0], i == 1, i == 3, i[1], 2'(3 - i)};
         @(posedge clk) {cd, rp} <= 2'h1;
         host_u.rd(10'h3F5, d, oe);
         chk(d, {i[1:0], i[0], i == 1 || i == 3, 1'b0, i[1], 2'(3 - i)});
         host_u.rd(10'h3F5, d, oe);
         chk(d, {i == 1 || i == 2, 1'b0, i[1], !i[0], 1'b0, i[1], i[0], !i[1]});
         @(posedge clk) {rp, wp, wcmd} <= 3'h0;
         repeat (3) @(posedge clk);
      end
      // Mid-run hardware reset: rate back to 250 code, density high
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      host_u.rd(10'h3F7, d, oe);
      chk(d, 8'h0A);
      chk({3'h0, rsel, drc, dens}, 8'h15);
      report_and_stop();
   end
endmodule
